// [design/vpiu_top.sv]
// vectored priority interrupt unit: merge, rank, arbitrate, nest
`timescale 1ns/10ps
`default_nettype none
`include "vpiu_map.svh"

// How it works
// - three levels, top over middle over bottom
// - equal or lower than in-service level refused
// - highest level wins among simultaneous vectors
// - same level: smallest vector address wins
// - 41 sources merged onto 10 vectors
// - vector 13H: line c, timer, group four, usb, remote
// - vector 1BH: line d, group five, base timer
// - vector 23H: timer high, line six, usb
// - vector 2BH: timer one, line seven, serial, audio
// - vector 33H: first serial, duplex receive
// - vector 3BH: serials, duplex transmit, audio end
// - vector 43H: converter, timers, usb handshakes
// - vector 4BH: port zero, pwm, timers, misc
module vpiu_top (
  input  wire logic                     MCLK_I,
  input  wire logic                     SYS_RST_I,
  // external pins, asynchronous
  input  wire logic                     EXT_IRQ_A_I,
  input  wire logic                     EXT_IRQ_B_I,
  input  wire logic                     EXT_IRQ_C_I,
  input  wire logic                     EXT_IRQ_D_I,
  input  wire logic                     EXT_IRQ_GROUP_FOUR_I,
  input  wire logic                     EXT_IRQ_GROUP_FIVE_I,
  input  wire logic                     EXT_IRQ_SIX_I,
  input  wire logic                     EXT_IRQ_SEVEN_I,
  input  wire logic                     PORT_ZERO_I,
  // on-chip peripheral requests, same clock
  input  wire logic                     TIMER_ZERO_LOW_HALF_I,
  input  wire logic                     USB_HOST_CORE_BUS_ACTIVE_I,
  input  wire logic                     REMOTE_RX_I,
  input  wire logic                     BASE_TIMER_I,
  input  wire logic                     TIMER_ZERO_HIGH_HALF_I,
  input  wire logic                     USB_HOST_CORE_ATTACH_I,
  input  wire logic                     USB_HOST_CORE_DETACH_I,
  input  wire logic                     USB_HOST_CORE_RESUME_I,
  input  wire logic                     TIMER_ONE_LOW_HALF_I,
  input  wire logic                     TIMER_ONE_HIGH_HALF_I,
  input  wire logic                     SYNC_SERIAL_FOURTH_I,
  input  wire logic                     AUDIO_PORT_START_I,
  input  wire logic                     SYNC_SERIAL_FIRST_I,
  input  wire logic                     FULL_DUPLEX_SERIAL_RX_I,
  input  wire logic                     ASYNC_SYNC_SERIAL_I,
  input  wire logic                     SYNC_SERIAL_THIRD_I,
  input  wire logic                     FULL_DUPLEX_SERIAL_TX_I,
  input  wire logic                     AUDIO_PORT_END_I,
  input  wire logic                     ANALOG_CONV_I,
  input  wire logic                     TIMER_SIX_I,
  input  wire logic                     TIMER_SEVEN_I,
  input  wire logic                     USB_HOST_CORE_ACK_I,
  input  wire logic                     USB_HOST_CORE_NAK_I,
  input  wire logic                     USB_HOST_CORE_ERROR_I,
  input  wire logic                     USB_HOST_CORE_STALL_I,
  input  wire logic                     PULSE_WIDTH_CHAN_A_I,
  input  wire logic                     PULSE_WIDTH_CHAN_B_I,
  input  wire logic                     TIMER_FOUR_I,
  input  wire logic                     TIMER_FIVE_I,
  input  wire logic                     USB_HOST_CORE_SOF_I,
  input  wire logic                     MEMORY_COPY_DONE_I,
  input  wire logic                     AUDIO_PORT_ERROR_I,
  // per vector: 1 selects the upper level, 0 the bottom level
  input  wire logic [`VPIU_NUM_VEC-1:0] LVL_HI_SEL_I,
  // processor core side
  input  wire logic                     VEC_ACK_I,
  input  wire logic                     SVC_DONE_I,
  output logic                          VEC_REQ_O,
  output logic      [`VPIU_ADDR_W-1:0]  VEC_ADDR_O,
  output vpiu_pkg::vpiu_lvl_e           VEC_LVL_O,
  output logic      [`VPIU_NUM_LVL-1:0] SVC_MASK_O
);
  import vpiu_pkg::*;

  // ----------------------------------------------------------------
  // vector address table
  // ----------------------------------------------------------------
  localparam logic [`VPIU_ADDR_W-1:0] VEC_ADDR [`VPIU_NUM_VEC] = '{
    `VPIU_VEC_ADDR_0, `VPIU_VEC_ADDR_1, `VPIU_VEC_ADDR_2,
    `VPIU_VEC_ADDR_3, `VPIU_VEC_ADDR_4, `VPIU_VEC_ADDR_5,
    `VPIU_VEC_ADDR_6, `VPIU_VEC_ADDR_7, `VPIU_VEC_ADDR_8,
    `VPIU_VEC_ADDR_9
  };

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [`VPIU_NUM_PINS-1:0] pin_raw;
  logic [`VPIU_NUM_PINS-1:0] pin_sync;

  assign pin_raw = {PORT_ZERO_I,
                    EXT_IRQ_SEVEN_I,
                    EXT_IRQ_SIX_I,
                    EXT_IRQ_GROUP_FIVE_I,
                    EXT_IRQ_D_I,
                    EXT_IRQ_GROUP_FOUR_I,
                    EXT_IRQ_C_I,
                    EXT_IRQ_B_I,
                    EXT_IRQ_A_I};

  // pins cost four cycles of latency; peripherals none
  vpiu_pin_sync #(
    .W (`VPIU_NUM_PINS)
  ) u_pin_sync (
    .clk_i (MCLK_I),
    .rst_i (SYS_RST_I),
    .pin_i (pin_raw),
    .pin_o (pin_sync)
  );

  logic ext_irq_a;
  logic ext_irq_b;
  logic ext_irq_c;
  logic ext_irq_group_four;
  logic ext_irq_d;
  logic ext_irq_group_five;
  logic ext_irq_six;
  logic ext_irq_seven;
  logic port_zero;

  assign {port_zero, ext_irq_seven, ext_irq_six, ext_irq_group_five,
          ext_irq_d, ext_irq_group_four, ext_irq_c, ext_irq_b,
          ext_irq_a} = pin_sync;

  // ----------------------------------------------------------------
  // source merging
  // ----------------------------------------------------------------
  // sources are level requests held by their owner until serviced
  logic [`VPIU_NUM_VEC-1:0] vec_req;

  assign vec_req[0] = ext_irq_a;
  assign vec_req[1] = ext_irq_b;
  assign vec_req[2] = ext_irq_c | TIMER_ZERO_LOW_HALF_I
                    | ext_irq_group_four | USB_HOST_CORE_BUS_ACTIVE_I
                    | REMOTE_RX_I;
  assign vec_req[3] = ext_irq_d | ext_irq_group_five | BASE_TIMER_I;
  assign vec_req[4] = TIMER_ZERO_HIGH_HALF_I | ext_irq_six
                    | USB_HOST_CORE_ATTACH_I | USB_HOST_CORE_DETACH_I
                    | USB_HOST_CORE_RESUME_I;
  assign vec_req[5] = TIMER_ONE_LOW_HALF_I | TIMER_ONE_HIGH_HALF_I
                    | ext_irq_seven | SYNC_SERIAL_FOURTH_I
                    | AUDIO_PORT_START_I;
  assign vec_req[6] = SYNC_SERIAL_FIRST_I | FULL_DUPLEX_SERIAL_RX_I;
  assign vec_req[7] = ASYNC_SYNC_SERIAL_I | SYNC_SERIAL_THIRD_I
                    | FULL_DUPLEX_SERIAL_TX_I | AUDIO_PORT_END_I;
  assign vec_req[8] = ANALOG_CONV_I | TIMER_SIX_I | TIMER_SEVEN_I
                    | USB_HOST_CORE_ACK_I | USB_HOST_CORE_NAK_I
                    | USB_HOST_CORE_ERROR_I | USB_HOST_CORE_STALL_I;
  assign vec_req[9] = port_zero | PULSE_WIDTH_CHAN_A_I
                    | PULSE_WIDTH_CHAN_B_I | TIMER_FOUR_I | TIMER_FIVE_I
                    | USB_HOST_CORE_SOF_I | MEMORY_COPY_DONE_I
                    | AUDIO_PORT_ERROR_I;

  // ----------------------------------------------------------------
  // level ranking
  // ----------------------------------------------------------------
  vpiu_lvl_e vec_lvl [`VPIU_NUM_VEC];

  genvar gi;
  generate
    for (gi = 0; gi < `VPIU_NUM_VEC; gi++) begin : g_rank
      // only the first two vectors reach top
      vpiu_lvl_rank #(
        .HI_LVL (vpiu_lvl_e'((gi < `VPIU_NUM_TOP_VEC) ? LVL_TOP : LVL_MID))
      ) u_rank (
        .req_i    (vec_req[gi]),
        .hi_sel_i (LVL_HI_SEL_I[gi]),
        .lvl_o    (vec_lvl[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // in-service level
  // ----------------------------------------------------------------
  logic [`VPIU_NUM_LVL-1:0] isr_q;
  logic [`VPIU_NUM_LVL-1:0] isr_d;
  vpiu_lvl_e                cur_lvl;

  // highest in-service bit sets the level
  always_comb begin
    if (isr_q[`VPIU_ISR_TOP]) begin
      cur_lvl = LVL_TOP;
    end else if (isr_q[`VPIU_ISR_MID]) begin
      cur_lvl = LVL_MID;
    end else if (isr_q[`VPIU_ISR_BOT]) begin
      cur_lvl = LVL_BOT;
    end else begin
      cur_lvl = LVL_NONE;
    end
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  vpiu_lvl_e              best_lvl;
  logic [`VPIU_IDX_W-1:0] best_idx;
  logic                   win;

  always_comb begin
    best_lvl = LVL_NONE;
    best_idx = `VPIU_IDX_RST;
    for (int i = 0; i < `VPIU_NUM_VEC; i++) begin
      // higher level replaces; strict compare keeps lowest index
      if (vec_lvl[i] > best_lvl) begin
        best_lvl = vec_lvl[i];
        best_idx = `VPIU_IDX_W'(i);
      end
    end
  end

  // must beat the level in service
  assign win = (best_lvl > cur_lvl);

  // ----------------------------------------------------------------
  // offer state machine
  // ----------------------------------------------------------------
  vpiu_state_e             state_q;
  vpiu_state_e             state_d;
  logic [`VPIU_ADDR_W-1:0] addr_q;
  logic [`VPIU_ADDR_W-1:0] addr_d;
  vpiu_lvl_e               lvl_q;
  vpiu_lvl_e               lvl_d;
  logic                    grant;

  assign grant = (state_q == ST_OFFER) & VEC_ACK_I;

  // offer is refreshed every cycle so a later, better request can
  // overtake before the core acknowledges
  always_comb begin
    state_d = state_q;
    addr_d  = addr_q;
    lvl_d   = lvl_q;
    case (state_q)
      ST_IDLE: begin
        if (win) begin
          state_d = ST_OFFER;
          addr_d  = VEC_ADDR[best_idx];
          lvl_d   = best_lvl;
        end
      end
      ST_OFFER: begin
        if (VEC_ACK_I) begin
          state_d = ST_IDLE;
        end else if (win) begin
          addr_d = VEC_ADDR[best_idx];
          lvl_d  = best_lvl;
        end else begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // nesting: pop on service done, push on grant
  // ----------------------------------------------------------------
  always_comb begin
    isr_d = isr_q;
    if (SVC_DONE_I) begin
      if (isr_q[`VPIU_ISR_TOP]) begin
        isr_d[`VPIU_ISR_TOP] = 1'b0;
      end else if (isr_q[`VPIU_ISR_MID]) begin
        isr_d[`VPIU_ISR_MID] = 1'b0;
      end else begin
        isr_d[`VPIU_ISR_BOT] = 1'b0;
      end
    end
    // granted level now blocks its equals
    if (grant) begin
      if (lvl_q == LVL_TOP) begin
        isr_d[`VPIU_ISR_TOP] = 1'b1;
      end else if (lvl_q == LVL_MID) begin
        isr_d[`VPIU_ISR_MID] = 1'b1;
      end else if (lvl_q == LVL_BOT) begin
        isr_d[`VPIU_ISR_BOT] = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state_q <= ST_IDLE;
      addr_q  <= `VPIU_ADDR_RST;
      lvl_q   <= LVL_NONE;
      isr_q   <= `VPIU_ISR_RST;
    end else begin
      state_q <= state_d;
      addr_q  <= addr_d;
      lvl_q   <= lvl_d;
      isr_q   <= isr_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign VEC_REQ_O  = (state_q == ST_OFFER);
  assign VEC_ADDR_O = addr_q;
  assign VEC_LVL_O  = lvl_q;
  assign SVC_MASK_O = isr_q;

endmodule

`default_nettype wire

// [design/vpiu_map.svh]
// named constants of the vectored priority interrupt unit
`ifndef VPIU_MAP_SVH
`define VPIU_MAP_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define VPIU_NUM_VEC       10
`define VPIU_NUM_PINS      9
`define VPIU_ADDR_W        20
`define VPIU_IDX_W         4
`define VPIU_NUM_LVL       3
`define VPIU_NUM_TOP_VEC   2

// ----------------------------------------------------------------
// vector addresses, smallest first
// ----------------------------------------------------------------
`define VPIU_VEC_ADDR_0    20'h00003
`define VPIU_VEC_ADDR_1    20'h0000B
`define VPIU_VEC_ADDR_2    20'h00013
`define VPIU_VEC_ADDR_3    20'h0001B
`define VPIU_VEC_ADDR_4    20'h00023
`define VPIU_VEC_ADDR_5    20'h0002B
`define VPIU_VEC_ADDR_6    20'h00033
`define VPIU_VEC_ADDR_7    20'h0003B
`define VPIU_VEC_ADDR_8    20'h00043
`define VPIU_VEC_ADDR_9    20'h0004B

// ----------------------------------------------------------------
// in-service bit positions and reset values
// ----------------------------------------------------------------
`define VPIU_ISR_BOT       0
`define VPIU_ISR_MID       1
`define VPIU_ISR_TOP       2
`define VPIU_ISR_RST       3'h0
`define VPIU_ADDR_RST      20'h00000
`define VPIU_IDX_RST       4'h0

`endif

// [design/vpiu_pkg.sv]
// types of the vectored priority interrupt unit
package vpiu_pkg;

  // ----------------------------------------------------------------
  // priority levels, numeric order is priority order
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LVL_NONE = 2'h0,
    LVL_BOT  = 2'h1,
    LVL_MID  = 2'h2,
    LVL_TOP  = 2'h3
  } vpiu_lvl_e;

  // ----------------------------------------------------------------
  // offer state machine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h1,
    ST_OFFER = 2'h2
  } vpiu_state_e;

endpackage

// [design/vpiu_pin_sync.sv]
// three-stage synchroniser with agreement filter for pin requests
`timescale 1ns/10ps
`default_nettype none

module vpiu_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] pin_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  // only bits where stages two and three agree move on
  always_comb begin
    out_d = (s2_q & ~(s2_q ^ s3_q)) | (out_q & (s2_q ^ s3_q));
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else begin
      s1_q  <= pin_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign pin_o = out_q;

endmodule

`default_nettype wire

// [design/vpiu_lvl_rank.sv]
// level of one vector from its merged request and level select
`timescale 1ns/10ps
`default_nettype none

module vpiu_lvl_rank #(
  parameter vpiu_pkg::vpiu_lvl_e HI_LVL = vpiu_pkg::LVL_MID
) (
  input  wire logic      req_i,
  input  wire logic      hi_sel_i,
  output vpiu_pkg::vpiu_lvl_e lvl_o
);
  import vpiu_pkg::*;

  always_comb begin
    if (!req_i) begin
      lvl_o = LVL_NONE;
    end else if (hi_sel_i) begin
      lvl_o = HI_LVL;
    end else begin
      lvl_o = LVL_BOT;
    end
  end

endmodule

`default_nettype wire

// [testbench/vpiu_core_model.sv]
// processor core model: takes offered vectors, reports handler returns
`timescale 1ns/10ps
`default_nettype none

module vpiu_core_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic [19:0] addr_i,
  input  wire logic        ack_en_i,
  input  wire logic [3:0]  wait_i,
  input  wire logic        done_cmd_i,
  output logic             ack_o,
  output logic             done_o,
  output logic             taken_o,
  output logic [19:0]      taken_addr_o
);
  logic [3:0] wait_q;

  // slow answers: ack only after wait_i cycles of a standing offer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_q       <= 4'h0;
      ack_o        <= 1'h0;
      done_o       <= 1'h0;
      taken_o      <= 1'h0;
      taken_addr_o <= 20'h0;
    end else begin
      wait_q  <= (req_i && !ack_o) ? wait_q + 4'h1 : 4'h0;
      ack_o   <= ack_en_i && req_i && !ack_o && (wait_q >= wait_i);
      done_o  <= done_cmd_i;
      taken_o <= req_i && ack_o;
      if (req_i && ack_o) begin
        taken_addr_o <= addr_i;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/vpiu_top_properties.sv]
// concurrent checks on the offer and in-service ports
`timescale 1ns/10ps
`default_nettype none

module vpiu_top_chk
  import vpiu_pkg::*;
(
  input  wire logic        MCLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        VEC_ACK_I,
  input  wire logic        SVC_DONE_I,
  input  wire logic        VEC_REQ_O,
  input  wire logic [19:0] VEC_ADDR_O,
  input  var  vpiu_lvl_e   VEC_LVL_O,
  input  wire logic [2:0]  SVC_MASK_O
);
  logic [1:0] svc_lvl;

  // highest level now in service
  assign svc_lvl = SVC_MASK_O[2] ? 2'h3 : SVC_MASK_O[1] ? 2'h2 :
                   SVC_MASK_O[0] ? 2'h1 : 2'h0;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_grant;
    VEC_REQ_O && VEC_ACK_I;
  endsequence
  sequence s_quiet;
    !VEC_ACK_I && !SVC_DONE_I;
  endsequence

  property p_grant_drop;
    s_grant |=> !VEC_REQ_O;
  endproperty
  a_grant_drop: assert property (p_grant_drop)
    else $error("offer still up after grant");
  property p_grant_push;
    s_grant ##0 !SVC_DONE_I |=> svc_lvl == $past(VEC_LVL_O);
  endproperty
  a_grant_push: assert property (p_grant_push)
    else $error("granted level not in service");
  property p_above;
    VEC_REQ_O |-> VEC_LVL_O > svc_lvl;
  endproperty
  a_above: assert property (p_above)
    else $error("offer not above level in service");
  property p_top_pin;
    VEC_REQ_O && VEC_LVL_O == LVL_TOP |-> VEC_ADDR_O inside {20'h3, 20'hB};
  endproperty
  a_top_pin: assert property (p_top_pin)
    else $error("top level on a later vector");
  property p_mid_vec;
    VEC_REQ_O && VEC_LVL_O == LVL_MID |-> VEC_ADDR_O >= 20'h13;
  endproperty
  a_mid_vec: assert property (p_mid_vec)
    else $error("middle level on a first pin vector");
  property p_addr_grid;
    VEC_REQ_O |-> VEC_ADDR_O[2:0] == 3'h3 && VEC_ADDR_O <= 20'h4B;
  endproperty
  a_addr_grid: assert property (p_addr_grid)
    else $error("offered address is no vector");
  property p_mask_hold;
    s_quiet |=> $stable(SVC_MASK_O);
  endproperty
  a_mask_hold: assert property (p_mask_hold)
    else $error("in-service mask moved by itself");
  property p_done_pop;
    SVC_DONE_I && !VEC_ACK_I && svc_lvl != 2'h0 |=> svc_lvl < $past(svc_lvl);
  endproperty
  a_done_pop: assert property (p_done_pop)
    else $error("return did not pop top level");
endmodule

bind vpiu_top vpiu_top_chk i_chk (.MCLK_I, .SYS_RST_I, .VEC_ACK_I,
  .SVC_DONE_I, .VEC_REQ_O, .VEC_ADDR_O, .VEC_LVL_O, .SVC_MASK_O);
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench of the vectored priority interrupt unit
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import vpiu_pkg::*;
  // first source bit of each vector, sources grouped by vector
  localparam int FIRST [11] = '{0, 1, 2, 7, 10, 15, 20, 22, 26, 33, 41};
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [40:0] src = 41'h0;
  logic [9:0]  sel = 10'h0;
  logic        ack_en = 1'h0;
  logic        done_cmd = 1'h0;
  logic [3:0]  wait_n = 4'h0;
  logic        ack, done, taken, req;
  logic [19:0] addr, taken_addr;
  vpiu_lvl_e   lvl;
  logic [2:0]  mask;
  int          num_errors = 0;
  int          n_compared = 0;

  always #5 clk = ~clk;

  vpiu_top i_dut (.MCLK_I(clk), .SYS_RST_I(rst),
    .EXT_IRQ_A_I(src[0]), .EXT_IRQ_B_I(src[1]), .EXT_IRQ_C_I(src[2]),
    .TIMER_ZERO_LOW_HALF_I(src[3]), .EXT_IRQ_GROUP_FOUR_I(src[4]),
    .USB_HOST_CORE_BUS_ACTIVE_I(src[5]), .REMOTE_RX_I(src[6]),
    .EXT_IRQ_D_I(src[7]), .EXT_IRQ_GROUP_FIVE_I(src[8]),
    .BASE_TIMER_I(src[9]), .TIMER_ZERO_HIGH_HALF_I(src[10]),
    .EXT_IRQ_SIX_I(src[11]), .USB_HOST_CORE_ATTACH_I(src[12]),
    .USB_HOST_CORE_DETACH_I(src[13]), .USB_HOST_CORE_RESUME_I(src[14]),
    .TIMER_ONE_LOW_HALF_I(src[15]), .TIMER_ONE_HIGH_HALF_I(src[16]),
    .EXT_IRQ_SEVEN_I(src[17]), .SYNC_SERIAL_FOURTH_I(src[18]),
    .AUDIO_PORT_START_I(src[19]), .SYNC_SERIAL_FIRST_I(src[20]),
    .FULL_DUPLEX_SERIAL_RX_I(src[21]), .ASYNC_SYNC_SERIAL_I(src[22]),
    .SYNC_SERIAL_THIRD_I(src[23]), .FULL_DUPLEX_SERIAL_TX_I(src[24]),
    .AUDIO_PORT_END_I(src[25]), .ANALOG_CONV_I(src[26]),
    .TIMER_SIX_I(src[27]), .TIMER_SEVEN_I(src[28]),
    .USB_HOST_CORE_ACK_I(src[29]), .USB_HOST_CORE_NAK_I(src[30]),
    .USB_HOST_CORE_ERROR_I(src[31]), .USB_HOST_CORE_STALL_I(src[32]),
    .PORT_ZERO_I(src[33]), .PULSE_WIDTH_CHAN_A_I(src[34]),
    .PULSE_WIDTH_CHAN_B_I(src[35]), .TIMER_FOUR_I(src[36]),
    .TIMER_FIVE_I(src[37]), .USB_HOST_CORE_SOF_I(src[38]),
    .MEMORY_COPY_DONE_I(src[39]), .AUDIO_PORT_ERROR_I(src[40]),
    .LVL_HI_SEL_I(sel), .VEC_ACK_I(ack), .SVC_DONE_I(done),
    .VEC_REQ_O(req), .VEC_ADDR_O(addr), .VEC_LVL_O(lvl), .SVC_MASK_O(mask));

  vpiu_core_model i_core (.clk_i(clk), .rst_i(rst), .req_i(req),
    .addr_i(addr), .ack_en_i(ack_en), .wait_i(wait_n),
    .done_cmd_i(done_cmd), .ack_o(ack), .done_o(done), .taken_o(taken),
    .taken_addr_o(taken_addr));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [19:0] va(input int v);
    return 20'h3 + 20'(v) * 20'h8;
  endfunction

  task automatic give_verdict();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [19:0] exp,
                     input logic [19:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // pin sources need the synchroniser, so allow a dozen edges
  task automatic wait_hi(input string what, ref logic s);
    for (int n = 0; n < 12 && s !== 1'h1; n++) begin
      @(posedge clk);
      #1;
    end
    if (s !== 1'h1) begin
      num_errors++;
      $display("unexpected timeout waiting for %s", what);
      give_verdict();
    end
  endtask

  task automatic grant();
    @(posedge clk);
    ack_en <= 1'h1;
    wait_hi("grant", taken);
    @(posedge clk);
    ack_en <= 1'h0;
  endtask

  task automatic pulse_done();
    @(posedge clk);
    done_cmd <= 1'h1;
    @(posedge clk);
    done_cmd <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_each_source();
    int v;
    logic [19:0] el;
    for (int i = 0; i < 41; i++) begin
      v = 0;
      while (FIRST[v + 1] <= i) v++;
      el = !i[0] ? 20'(LVL_BOT) : (v < 2 ? 20'(LVL_TOP) : 20'(LVL_MID));
      @(posedge clk);
      sel <= {10{i[0]}};
      src <= 41'h1 << i;
      wait_hi("offer", req);
      chk("vector", va(v), addr);
      chk("level", el, 20'(lvl));
      grant();
      chk("taken vector", va(v), taken_addr);
      chk("mask", 20'h1 << (el - 20'h1), 20'(mask));
      repeat (3) @(posedge clk);
      #1;
      chk("re-offer at equal level", 20'h0, 20'(req));
      @(posedge clk);
      src <= 41'h0;
      repeat (8) @(posedge clk);
      pulse_done();
      chk("mask after return", 20'h0, 20'(mask));
    end
  endtask

  task automatic t_arbitrate();
    @(posedge clk);
    sel <= 10'h301;
    src <= (41'h1 << 9) | (41'h1 << 27) | (41'h1 << 36);
    wait_hi("offer", req);
    chk("winner", va(8), addr);
    chk("winner level", 20'(LVL_MID), 20'(lvl));
    grant();
    // handler of vector 43H clears its source, the top pin rises
    src <= 41'h1 | (41'h1 << 9) | (41'h1 << 36);
    repeat (2) @(posedge clk);
    #1;
    chk("equal or lower offered", 20'h0, 20'(req));
    wait_hi("nested offer", req);
    chk("nested vector", va(0), addr);
    chk("nested level", 20'(LVL_TOP), 20'(lvl));
    grant();
    chk("nested mask", 20'h6, 20'(mask));
    src[0] <= 1'h0;
    repeat (8) @(posedge clk);
    pulse_done();
    chk("mask after top return", 20'h2, 20'(mask));
    chk("offer under middle", 20'h0, 20'(req));
    wait_n <= 4'h3;
    pulse_done();
    wait_hi("offer after return", req);
    chk("next winner", va(9), addr);
    grant();
    chk("slow grant mask", 20'h2, 20'(mask));
    src <= 41'h0;
    repeat (4) @(posedge clk);
    pulse_done();
    chk("final mask", 20'h0, 20'(mask));
  endtask

  // a better request arriving while an offer stands replaces it
  task automatic t_overtake();
    @(posedge clk);
    sel <= 10'h204;
    src <= 41'h1 << 36;
    wait_hi("offer", req);
    chk("first offer", va(9), addr);
    @(posedge clk);
    src[3] <= 1'h1;
    @(posedge clk);
    #1;
    chk("overtaken offer", va(2), addr);
    chk("overtaken level", 20'(LVL_MID), 20'(lvl));
    grant();
    chk("overtaken grant", va(2), taken_addr);
    chk("overtaken mask", 20'h2, 20'(mask));
    src <= 41'h0;
    repeat (2) @(posedge clk);
    pulse_done();
    chk("mask after overtake", 20'h0, 20'(mask));
    chk("offer after overtake", 20'h0, 20'(req));
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    t_each_source();
    t_arbitrate();
    t_overtake();
    give_verdict();
  end
endmodule
`default_nettype wire
